//--- verilog/stcd_top.sv
// Serial management slave, transmit disable and laser fault control
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Device address 0xA0 serves a 256-byte identification space, bytes 0 to 255.
// - Device address 0xA2 serves a separate 256-byte diagnostic space.
// - Serial slave uses small-EEPROM two-wire signalling and transaction format.
// - Diagnostic space shows live temperature, supply, bias, transmit and receive power.
// - Shutoff input high turns transmitter off; low allows normal operation.
// - Shutoff input defaults to disabled; transmitter off until host drives it low.
// - Bit 6 of diagnostic byte 110 is a host-writable software transmit disable.
// - Transmitter disabled when software bit OR hardware shutoff pin is set.
// - Bit 7 of byte 110 reads back current transmit-disable state.
// - Laser fault drives fault output high and disables laser; low otherwise.
// - Fault output latches high until cleared, even after fault goes away.
// - Fault clears only by toggling shutoff input or power cycling.
// - Bit 2 of byte 110 mirrors the transmitter fault condition.
// - Safety monitor checks transmit power and disables transmitter when unsafe.
// - Bit 1 of byte 110 mirrors receive signal lost; high means input unusable.
module stcd_top (
    // Core clock and reset
    input  wire logic                   core_clk_i,
    input  wire logic                   rstn_i,
    // Laser driver clock
    input  wire logic                   laser_clk_i,
    // Two-wire management pins
    input  wire logic                   scl_i,
    input  wire logic                   sda_i,
    output logic                        sda_o,
    output logic                        sda_oe_o,
    // Module control and status pins
    input  wire logic                   tx_disable_i,
    input  wire logic                   receive_signal_lost_i,
    output logic                        tx_fault_o,
    output logic                        tx_fault_oe_o,
    // Laser driver side
    input  wire logic                   laser_fault_i,
    input  wire logic [15:0]            tx_power_i,
    output logic                        laser_en_o,
    // Live analog monitor samples
    input  wire stcd_pkg::stcd_monitor_t monitor_i
);

    import stcd_pkg::*;

    stcd_link_t       s_reg;
    stcd_link_t       s_next;
    stcd_laser_t      l_reg;
    stcd_laser_t      l_next;

    logic [4:0]       core_sync;
    logic             scl_s;
    logic             sda_s;
    logic             dis_pin_s;
    logic             los_s;
    logic             fault_s;
    logic [2:0]       laser_sync;
    logic             l_rstn;
    logic             dis_pin_l;
    logic             soft_dis_l;

    logic             start_ev;
    logic             stop_ev;
    logic             rise_ev;
    logic             fall_ev;
    logic [7:0]       ctrl_live;
    logic [7:0]       rd_data;
    logic [9:0][7:0]  mon_arr;
    logic             soft_dis;
    logic             in_mon;
    logic             unsafe;
    logic             clr_ev;

    // Pin levels and the laser-side fault into the core domain
    stcd_sync2 #(
        .W (5)
    ) u_core_sync (
        .clk_i (core_clk_i),
        .d_i   ({scl_i, sda_i, tx_disable_i, receive_signal_lost_i, l_reg.fault}),
        .q_o   (core_sync)
    );

    assign {scl_s, sda_s, dis_pin_s, los_s, fault_s} = core_sync;
    assign soft_dis = s_reg.diag_mem[CTRL_OFFS][BIT_SOFT_DIS];

    // Reset, shutoff pin and software disable into the laser domain
    stcd_sync2 #(
        .W (3)
    ) u_laser_sync (
        .clk_i (laser_clk_i),
        .d_i   ({rstn_i, tx_disable_i, soft_dis}),
        .q_o   (laser_sync)
    );

    assign {l_rstn, dis_pin_l, soft_dis_l} = laser_sync;

    // Live status byte and read data
    always_comb begin
        ctrl_live                = 8'h00;
        ctrl_live[BIT_DIS_STATE] = dis_pin_s | soft_dis;
        ctrl_live[BIT_SOFT_DIS]  = soft_dis;
        ctrl_live[BIT_FAULT]     = fault_s;
        ctrl_live[BIT_LOS]       = los_s;
        mon_arr                  = monitor_i;
        in_mon                   = (s_reg.addr >= MON_FIRST) && (s_reg.addr <= MON_LAST);
        if (!s_reg.diag_sel) begin
            rd_data = s_reg.base_mem[s_reg.addr];
        end else if (s_reg.addr == CTRL_OFFS) begin
            rd_data = ctrl_live;
        end else if (in_mon) begin
            rd_data = mon_arr[4'(MON_LAST - s_reg.addr)];
        end else begin
            rd_data = s_reg.diag_mem[s_reg.addr];
        end
    end

    // Bus conditions from the settled samples
    always_comb begin
        start_ev = s_reg.scl_q & scl_s & s_reg.sda_q & ~sda_s;
        stop_ev  = s_reg.scl_q & scl_s & ~s_reg.sda_q & sda_s;
        rise_ev  = ~s_reg.scl_q & scl_s;
        fall_ev  = s_reg.scl_q & ~scl_s;
    end

    // Serial slave, EEPROM-style framing
    always_comb begin
        s_next       = s_reg;
        s_next.scl_q = scl_s;
        s_next.sda_q = sda_s;
        if (start_ev) begin
            s_next.phase  = PH_DEV;
            s_next.bitc   = 4'h0;
            s_next.sda_oe = 1'b0;
        end else if (stop_ev) begin
            s_next.phase  = PH_IDLE;
            s_next.sda_oe = 1'b0;
        end else if (rise_ev) begin
            unique case (s_reg.phase)
                PH_DEV, PH_WRITE: begin
                    s_next.shreg = {s_reg.shreg[6:0], sda_s};
                    s_next.bitc  = s_reg.bitc + 4'h1;
                end
                PH_READ: begin
                    s_next.bitc = s_reg.bitc + 4'h1;
                end
                PH_READ_ACK: begin
                    if (sda_s) begin
                        s_next.phase = PH_IDLE;
                    end
                end
                PH_IDLE, PH_ACK_DEV, PH_ACK_WR: begin
                end
                default: begin
                    s_next.phase = PH_IDLE;
                end
            endcase
        end else if (fall_ev) begin
            unique case (s_reg.phase)
                PH_DEV: begin
                    if (s_reg.bitc == BITS_PER_BYTE) begin
                        if (s_reg.shreg[7:1] == DEV_BASE[7:1] || s_reg.shreg[7:1] == DEV_DIAG[7:1]) begin
                            s_next.diag_sel = (s_reg.shreg[7:1] == DEV_DIAG[7:1]);
                            s_next.rd       = s_reg.shreg[0];
                            s_next.sda_oe   = 1'b1;
                            s_next.phase    = PH_ACK_DEV;
                        end else begin
                            s_next.phase = PH_IDLE;
                        end
                    end
                end
                PH_ACK_DEV: begin
                    s_next.bitc = 4'h0;
                    if (s_reg.rd) begin
                        s_next.shreg  = rd_data;
                        s_next.sda_oe = ~rd_data[7];
                        s_next.phase  = PH_READ;
                    end else begin
                        s_next.sda_oe     = 1'b0;
                        s_next.addr_phase = 1'b1;
                        s_next.phase      = PH_WRITE;
                    end
                end
                PH_WRITE: begin
                    if (s_reg.bitc == BITS_PER_BYTE) begin
                        s_next.sda_oe = 1'b1;
                        s_next.phase  = PH_ACK_WR;
                        if (s_reg.addr_phase) begin
                            s_next.addr       = s_reg.shreg;
                            s_next.addr_phase = 1'b0;
                        end else begin
                            s_next.addr = s_reg.addr + 8'h01;
                            if (!s_reg.diag_sel) begin
                                s_next.base_mem[s_reg.addr] = s_reg.shreg;
                            end else if (s_reg.addr == CTRL_OFFS) begin
                                s_next.diag_mem[CTRL_OFFS][BIT_SOFT_DIS] = s_reg.shreg[BIT_SOFT_DIS];
                            end else if (!in_mon) begin
                                s_next.diag_mem[s_reg.addr] = s_reg.shreg;
                            end
                        end
                    end
                end
                PH_ACK_WR: begin
                    s_next.sda_oe = 1'b0;
                    s_next.bitc   = 4'h0;
                    s_next.phase  = PH_WRITE;
                end
                PH_READ: begin
                    if (s_reg.bitc == BITS_PER_BYTE) begin
                        s_next.sda_oe = 1'b0;
                        s_next.addr   = s_reg.addr + 8'h01;
                        s_next.phase  = PH_READ_ACK;
                    end else begin
                        s_next.sda_oe = ~s_reg.shreg[3'(7 - s_reg.bitc)];
                    end
                end
                PH_READ_ACK: begin
                    s_next.shreg  = rd_data;
                    s_next.sda_oe = ~rd_data[7];
                    s_next.bitc   = 4'h0;
                    s_next.phase  = PH_READ;
                end
                PH_IDLE: begin
                end
                default: begin
                    s_next.phase  = PH_IDLE;
                    s_next.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            s_reg       <= '0;
            s_reg.scl_q <= BUS_IDLE_LVL;
            s_reg.sda_q <= BUS_IDLE_LVL;
        end else begin
            s_reg <= s_next;
        end
    end

    // Laser side: disable, fault latch and eye safety
    always_comb begin
        unsafe          = tx_power_i > EYE_SAFE_LIMIT;
        clr_ev          = dis_pin_l & ~l_reg.dis_q;
        l_next          = l_reg;
        l_next.dis_q    = dis_pin_l;
        // A new fault wins over a clear in the same cycle
        l_next.fault    = laser_fault_i | unsafe | (l_reg.fault & ~clr_ev);
        l_next.laser_en = ~(dis_pin_l | soft_dis_l | l_reg.fault | laser_fault_i | unsafe);
        l_next.fault_val = 1'b0;
        // Open-drain: pull low while no fault, release to go high on fault
        l_next.fault_oe = ~l_next.fault;
    end

    always_ff @(posedge laser_clk_i) begin
        if (!l_rstn) begin
            l_reg          <= '0;
            l_reg.dis_q    <= DIS_PIN_RST;
            l_reg.fault_oe <= 1'b1;
        end else begin
            l_reg <= l_next;
        end
    end

    assign sda_o         = s_reg.sda_val;
    assign sda_oe_o      = s_reg.sda_oe;
    assign laser_en_o    = l_reg.laser_en;
    assign tx_fault_o    = l_reg.fault_val;
    assign tx_fault_oe_o = l_reg.fault_oe;

endmodule // stcd_top

`default_nettype wire

//--- verilog/stcd_pkg.sv
// Shared constants and types for the transceiver control and diagnostic block
package stcd_pkg;

    // Serial device addresses (8-bit form, R/W bit in bit 0)
    localparam logic [7:0] DEV_BASE      = 8'ha0;
    localparam logic [7:0] DEV_DIAG      = 8'ha2;

    // Control and status byte in the diagnostic space
    localparam logic [7:0] CTRL_OFFS     = 8'h6e;
    localparam int         BIT_DIS_STATE = 7;
    localparam int         BIT_SOFT_DIS  = 6;
    localparam int         BIT_FAULT     = 2;
    localparam int         BIT_LOS       = 1;

    // Live monitor window: temp, vcc, bias, tx power, rx power, 16 bits each, high byte first
    localparam logic [7:0] MON_FIRST     = 8'h60;
    localparam logic [7:0] MON_LAST      = 8'h69;

    // Eye safety trip level on the transmit power sample
    localparam logic [15:0] EYE_SAFE_LIMIT = 16'he000;

    // Serial framing
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // Reset values
    localparam logic       BUS_IDLE_LVL  = 1'b1;
    localparam logic       DIS_PIN_RST   = 1'b1;

    typedef enum logic [2:0] {
        PH_IDLE     = 3'b000,
        PH_DEV      = 3'b001,
        PH_ACK_DEV  = 3'b010,
        PH_WRITE    = 3'b011,
        PH_ACK_WR   = 3'b100,
        PH_READ     = 3'b101,
        PH_READ_ACK = 3'b110
    } stcd_phase_t;

    typedef struct packed {
        logic [15:0] temp;
        logic [15:0] vcc;
        logic [15:0] bias;
        logic [15:0] tx_pwr;
        logic [15:0] rx_pwr;
    } stcd_monitor_t;

    typedef struct packed {
        logic [255:0][7:0] base_mem;
        logic [255:0][7:0] diag_mem;
        stcd_phase_t       phase;
        logic [3:0]        bitc;
        logic [7:0]        shreg;
        logic [7:0]        addr;
        logic              diag_sel;
        logic              rd;
        logic              addr_phase;
        logic              scl_q;
        logic              sda_q;
        logic              sda_val;
        logic              sda_oe;
    } stcd_link_t;

    typedef struct packed {
        logic dis_q;
        logic fault;
        logic laser_en;
        logic fault_val;
        logic fault_oe;
    } stcd_laser_t;

endpackage

//--- verilog/stcd_sync2.sv
// Two-stage synchroniser for a bundle of levels
`timescale 1ns/10ps
`default_nettype none

module stcd_sync2 #(
    parameter int W = 1
) (
    // Clock
    input  wire logic         clk_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [1:0][W-1:0] stage_reg;
    logic [1:0][W-1:0] stage_next;

    always_comb begin
        stage_next    = stage_reg;
        stage_next[0] = d_i;
        stage_next[1] = stage_reg[0];
    end

    always_ff @(posedge clk_i) begin
        stage_reg <= stage_next;
    end

    assign q_o = stage_reg[1];

endmodule // stcd_sync2

`default_nettype wire

//--- testbench/stcd_top_sva.sv
// Pin-level assertions for the transceiver control block
`timescale 1ns/10ps
`default_nettype none
module stcd_top_sva
    import stcd_pkg::*;
(
    // Clocks and reset
    input wire logic        core_clk_i,
    input wire logic        rstn_i,
    input wire logic        laser_clk_i,
    // Watched pins
    input wire logic        scl_i,
    input wire logic        sda_oe_o,
    input wire logic        tx_disable_i,
    input wire logic        tx_fault_oe_o,
    input wire logic        laser_fault_i,
    input wire logic [15:0] tx_power_i,
    input wire logic        laser_en_o
);
    sequence s_pin_low;
        !tx_disable_i [*4];
    endsequence
    sequence s_pin_high;
        tx_disable_i [*5];
    endsequence
    property p_fault_set;
        @(posedge laser_clk_i) disable iff (!rstn_i) laser_fault_i |=> !tx_fault_oe_o && !laser_en_o;
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault not flagged");
    property p_fault_off;
        @(posedge laser_clk_i) disable iff (!rstn_i) !tx_fault_oe_o |-> !laser_en_o;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("laser on with fault");
    property p_fault_hold;
        @(posedge laser_clk_i) disable iff (!rstn_i) s_pin_low ##0 !tx_fault_oe_o |=> !tx_fault_oe_o;
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault dropped");
    property p_fault_clr;
        @(posedge laser_clk_i) disable iff (!rstn_i)
            $rose(tx_fault_oe_o) |-> $past(tx_disable_i, 3) && !$past(tx_disable_i, 4);
    endproperty
    a_fault_clr: assert property (p_fault_clr) else $error("fault cleared alone");
    property p_pin_off;
        @(posedge laser_clk_i) disable iff (!rstn_i) s_pin_high |-> !laser_en_o;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("laser on, pin high");
    property p_en_rise;
        @(posedge laser_clk_i) disable iff (!rstn_i) $rose(laser_en_o) |-> !$past(tx_disable_i, 3);
    endproperty
    a_en_rise: assert property (p_en_rise) else $error("laser on too early");
    property p_eye;
        @(posedge laser_clk_i) disable iff (!rstn_i) (tx_power_i > EYE_SAFE_LIMIT) |=> !laser_en_o;
    endproperty
    a_eye: assert property (p_eye) else $error("unsafe power kept");
    property p_ack_edge;
        @(posedge core_clk_i) disable iff (!rstn_i) $changed(sda_oe_o) |-> !scl_i;
    endproperty
    a_ack_edge: assert property (p_ack_edge) else $error("data moved, clock high");
endmodule // stcd_top_sva
bind stcd_top stcd_top_sva u_sva (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .laser_clk_i(laser_clk_i), .scl_i(scl_i),
    .sda_oe_o(sda_oe_o), .tx_disable_i(tx_disable_i), .tx_fault_oe_o(tx_fault_oe_o),
    .laser_fault_i(laser_fault_i), .tx_power_i(tx_power_i), .laser_en_o(laser_en_o)
);
`default_nettype wire

//--- testbench/stcd_host_model.sv
// Host controller model driving the two-wire bus
`timescale 1ns/10ps
`default_nettype none
module stcd_host_model (
    // Clock and wire level
    input  wire logic clk_i,
    input  wire logic sda_i,
    // Bus drive
    output var logic  scl_o,
    output var logic  sda_low_o
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic start();
        sda_low_o = 1'b0;
        w(5);
        scl_o = 1'b1;
        w(10);
        sda_low_o = 1'b1;
        w(10);
        scl_o = 1'b0;
        w(5);
    endtask
    task automatic stop();
        sda_low_o = 1'b1;
        w(5);
        scl_o = 1'b1;
        w(10);
        sda_low_o = 1'b0;
        w(10);
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_low_o = !b;
        w(5);
        scl_o = 1'b1;
        w(5);
        r = sda_i;
        w(5);
        scl_o = 1'b0;
        w(5);
    endtask
    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic get(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask
endmodule // stcd_host_model
`default_nettype wire

//--- testbench/test_sfp_transmit_control_and_diag.sv
// Self-checking bench for the transceiver control block
`timescale 1ns/10ps
`default_nettype none
module test_sfp_transmit_control_and_diag;
    import stcd_pkg::*;
    logic          core_clk_i = 1'b0;
    logic          laser_clk_i = 1'b0;
    logic          rstn_i = 1'b0;
    logic          dis = 1'b1;
    logic          los = 1'b0;
    logic          lf = 1'b0;
    logic [15:0]   pwr = 16'h1000;
    stcd_monitor_t mon = '0;
    logic          scl, sda_low, sda_oe, en, f_oe, k, sda_v, f_v;
    logic [15:0]   v;
    wire logic     sda_w;
    wire logic     fault_w;
    int            n_errors = 0;
    int            compares = 0;
    // Pull-ups on the data wire and the fault line
    assign sda_w   = !sda_low && (sda_oe ? sda_v : 1'b1);
    assign fault_w = f_oe ? f_v : 1'b1;
    always #50 core_clk_i = !core_clk_i;
    always #15 laser_clk_i = !laser_clk_i;
    stcd_top uut (
        .core_clk_i(core_clk_i), .rstn_i(rstn_i), .laser_clk_i(laser_clk_i), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_v), .sda_oe_o(sda_oe), .tx_disable_i(dis), .receive_signal_lost_i(los), .tx_fault_o(f_v),
        .tx_fault_oe_o(f_oe), .laser_fault_i(lf), .tx_power_i(pwr), .laser_en_o(en), .monitor_i(mon)
    );
    stcd_host_model host (.clk_i(core_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_low_o(sda_low));
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("MISMATCH t=%0t %s", $time, m);
        end
    endtask
    task automatic wrap_up();
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wr(input logic [7:0] dev, a, input logic [15:0] d, input int n);
        host.start();
        host.put(dev, k);
        chk(k === 1'b1, "no ack dev");
        host.put(a, k);
        for (int i = n; i > 0; i--) host.put(d[8*i-1 -: 8], k);
        chk(k === 1'b1, "no ack data");
        host.stop();
    endtask
    task automatic rd(input logic [7:0] dev, a, input int n, output logic [15:0] r);
        logic [7:0] b;
        r = '0;
        host.start();
        host.put(dev, k);
        host.put(a, k);
        host.start();
        host.put(dev | 8'h01, k);
        chk(k === 1'b1, "no ack read");
        for (int i = n; i > 0; i--) begin
            host.get(i == 1, b);
            r = {r[7:0], b};
        end
        host.stop();
    endtask
    task automatic t_base();
        wr(DEV_BASE, 8'hff, 16'h5aa5, 2);
        rd(DEV_BASE, 8'hff, 2, v);
        chk(v === 16'h5aa5, "base wrap");
        rd(DEV_DIAG, 8'hff, 2, v);
        chk(v === 16'h0000, "spaces shared");
        host.start();
        host.put(8'ha4, k);
        chk(k === 1'b0, "foreign acked");
        host.stop();
    endtask
    task automatic t_mon();
        mon = {16'h1234, 16'h3344, 16'h5566, 16'h7788, 16'h99aa};
        for (int i = 0; i < 5; i++) begin
            rd(DEV_DIAG, MON_FIRST + 8'(2 * i), 2, v);
            chk(v === mon[79 - 16 * i -: 16], "monitor");
        end
        mon.temp = 16'h0bcd;
        rd(DEV_DIAG, MON_FIRST, 2, v);
        chk(v === 16'h0bcd, "monitor stale");
    endtask
    task automatic t_ctrl();
        dis = 1'b0;
        los = 1'b1;
        wr(DEV_DIAG, CTRL_OFFS, 16'h00ff, 1);
        rd(DEV_DIAG, CTRL_OFFS, 1, v);
        chk(v === 16'h00c2, "ctrl soft");
        chk(en === 1'b0, "soft ignored");
        los = 1'b0;
        wr(DEV_DIAG, CTRL_OFFS, 16'h0000, 1);
        rd(DEV_DIAG, CTRL_OFFS, 1, v);
        chk(v === 16'h0000, "ctrl clear");
        chk(en === 1'b1, "laser off");
        dis = 1'b1;
        rd(DEV_DIAG, CTRL_OFFS, 1, v);
        chk(v === 16'h0080, "ctrl pin");
        chk(en === 1'b0, "pin ignored");
    endtask
    // Shutoff pulses come far closer than the host minimum; the block does not time the spacing
    task automatic toggle();
        dis = 1'b1;
        cyc(3);
        dis = 1'b0;
        cyc(3);
    endtask
    task automatic t_fault();
        toggle();
        lf = 1'b1;
        cyc(1);
        lf = 1'b0;
        cyc(20);
        chk(f_oe === 1'b0 && en === 1'b0 && fault_w === 1'b1, "fault lost");
        rd(DEV_DIAG, CTRL_OFFS, 1, v);
        chk(v === 16'h0004, "fault bit");
        toggle();
        chk(f_oe === 1'b1 && en === 1'b1 && fault_w === 1'b0, "fault stuck");
    endtask
    task automatic t_eye();
        pwr = EYE_SAFE_LIMIT;
        cyc(2);
        chk(en === 1'b1, "trip at limit");
        pwr = 16'he001;
        cyc(1);
        pwr = 16'h1000;
        cyc(2);
        chk(en === 1'b0 && f_oe === 1'b0, "unsafe kept");
        toggle();
        chk(en === 1'b1, "trip stuck");
    endtask
    initial begin
        cyc(5);
        rstn_i = 1'b1;
        cyc(5);
        chk(en === 1'b0 && f_oe === 1'b1 && fault_w === 1'b0, "reset state");
        t_base();
        t_mon();
        t_ctrl();
        t_fault();
        t_eye();
        wrap_up();
    end
    initial begin
        cyc(90000);
        n_errors++;
        $display("MISMATCH t=%0t run limit reached", $time);
        wrap_up();
    end
endmodule // test_sfp_transmit_control_and_diag
`default_nettype wire
